// file: src/brc_buck_ctrl.sv
// Control register bank for the two core, the processor and the memory buck converters.
// Assumes an Avalon-MM master, synchronous control inputs and sequencer step pulses.
`timescale 1ns/1ps
module brc_buck_ctrl (
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_SYS_RST,
    // Avalon-MM slave
    input  wire logic [7:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    // Control inputs
    input  wire logic        I_FIRST_CONTROL_INPUT,
    input  wire logic        I_SECOND_CONTROL_INPUT,
    input  wire logic        I_THIRD_CONTROL_INPUT,
    // Sequencer and configuration
    input  wire logic [3:0]  I_SEQ_STEP,
    input  wire logic        I_SEQ_SWITCH_STEP,
    input  wire logic        I_DUAL_PHASE,
    input  wire logic        I_MEM_DEFAULT_SUPPLY,
    // Converter controls
    output logic      [3:0]  O_CONVERTER_ON,
    output logic      [3:0]  O_VOLTAGE_ALTERNATE,
    output logic             O_CORE_SWITCH_CLOSED
);

    // Register storage and per-converter voltage choice
    logic [7:0]             reg_q [brc_pkg::NUM_CONV];
    logic [7:0]             reg_d [brc_pkg::NUM_CONV];
    logic [3:0]             vsel_q;
    logic [3:0]             vsel_d;

    // Bus handshake
    brc_pkg::brc_bus_state_type bus_state_q;
    brc_pkg::brc_bus_state_type bus_state_d;
    logic                   waitreq_q;
    logic                   waitreq_d;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;

    // Output registers
    logic [3:0]             conv_on_q;
    logic [3:0]             volt_alt_q;
    logic                   switch_q;

    // Control input transitions
    wire  [2:0]             gpi_level;
    wire  [2:0]             gpi_rise;
    wire  [2:0]             gpi_fall;

    assign gpi_level = {I_THIRD_CONTROL_INPUT, I_SECOND_CONTROL_INPUT, I_FIRST_CONTROL_INPUT};

    brc_input_edges u_edges (
        .i_clk   (I_SYS_CLK),
        .i_rst   (I_SYS_RST),
        .i_level (gpi_level),
        .o_rise  (gpi_rise),
        .o_fall  (gpi_fall)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire  [5:0]             addr_idx;
    wire                    addr_aligned;
    wire                    addr_hit;
    wire  [1:0]             addr_slot;
    wire                    bus_req;
    wire                    bus_done;
    wire                    wr_commit;
    wire  [7:0]             wr_byte;

    assign addr_idx     = I_AVS_ADDRESS[brc_pkg::ADDR_W-1:brc_pkg::ADDR_LSB];
    assign addr_aligned = (I_AVS_ADDRESS[brc_pkg::ADDR_LSB-1:0] == brc_pkg::ADDR_ALIGNED);
    assign addr_hit     = addr_aligned
                       && (addr_idx >= brc_pkg::CORE_TWO_BUCK_CONTROL_IDX)
                       && (addr_idx <= brc_pkg::MEMORY_BUCK_CONTROL_IDX);
    assign addr_slot    = brc_pkg::SLOT_W'(addr_idx - brc_pkg::CORE_TWO_BUCK_CONTROL_IDX);
    assign bus_req      = I_AVS_READ || I_AVS_WRITE;

    // The access completes at the edge where waitrequest is sampled low
    assign bus_done     = (bus_state_q == brc_pkg::BUS_ACK);
    assign wr_commit    = bus_done && I_AVS_WRITE && addr_hit && I_AVS_BYTEENABLE[0];
    assign wr_byte      = I_AVS_WRITEDATA[brc_pkg::REG_W-1:0];

    // Read value; unmapped or misaligned addresses read as zero
    wire  [31:0]            rd_value;

    assign rd_value = addr_hit ? {brc_pkg::RDATA_PAD, reg_q[addr_slot]} : brc_pkg::RDATA_RESET;

    // ------------------------------------------------------------------
    // Bus handshake: one wait cycle, then one acknowledge cycle
    // ------------------------------------------------------------------
    always_comb begin
        bus_state_d = bus_state_q;
        waitreq_d   = 1'b1;
        rdata_d     = rdata_q;
        unique case (bus_state_q)
            brc_pkg::BUS_IDLE: begin
                if (bus_req) begin
                    bus_state_d = brc_pkg::BUS_ACK;
                    waitreq_d   = 1'b0;
                    if (I_AVS_READ) begin
                        rdata_d = rd_value;
                    end
                end
            end
            brc_pkg::BUS_ACK: begin
                bus_state_d = brc_pkg::BUS_IDLE;
                waitreq_d   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            bus_state_q <= brc_pkg::BUS_IDLE;
            waitreq_q   <= 1'b1;
            rdata_q     <= brc_pkg::RDATA_RESET;
        end else begin
            bus_state_q <= bus_state_d;
            waitreq_q   <= waitreq_d;
            rdata_q     <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Per-converter control
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < brc_pkg::NUM_CONV; gi++) begin : g_conv
            wire  [1:0] en_src;
            wire  [1:0] vsel_src;
            wire        wr_here;
            wire        frozen;
            wire        en_rise;
            wire        en_fall;
            wire        v_rise;
            wire        v_fall;
            wire        seq_allowed;
            wire        seq_apply;
            wire        on_next;
            wire        sw_next;
            wire  [7:0] stored;

            assign en_src   = reg_q[gi][brc_pkg::ENABLE_SOURCE_MSB:brc_pkg::ENABLE_SOURCE_LSB];
            assign vsel_src = reg_q[gi][brc_pkg::VSEL_SOURCE_MSB:brc_pkg::VSEL_SOURCE_LSB];
            assign wr_here  = wr_commit && (addr_slot == brc_pkg::SLOT_W'(gi));

            // Core two ignores input transitions and sequencer steps, but not software writes, while the core pair runs dual-phase
            assign frozen   = (gi == brc_pkg::SLOT_CORE_TWO) && I_DUAL_PHASE;

            // Source 00 yields no event from any input
            assign en_rise  = brc_pkg::brc_src_event(en_src, gpi_rise);
            assign en_fall  = brc_pkg::brc_src_event(en_src, gpi_fall);
            assign v_rise   = brc_pkg::brc_src_event(vsel_src, gpi_rise);
            assign v_fall   = brc_pkg::brc_src_event(vsel_src, gpi_fall);

            // Memory converter follows the sequencer only as a default supply
            assign seq_allowed = (gi != brc_pkg::SLOT_MEM) || I_MEM_DEFAULT_SUPPLY;
            assign seq_apply   = I_SEQ_STEP[gi] && seq_allowed
                              && (brc_pkg::brc_src_type'(en_src) == brc_pkg::SRC_SEQUENCER);

            // Software write first, then input transitions, then sequencer step
            assign on_next = wr_here ? wr_byte[brc_pkg::BIT_CONVERTER_ON] :
                             frozen  ? reg_q[gi][brc_pkg::BIT_CONVERTER_ON] :
                             en_rise ? 1'b1 :
                             en_fall ? 1'b0 :
                             seq_apply ? reg_q[gi][brc_pkg::BIT_SEQUENCER_TARGET] :
                             reg_q[gi][brc_pkg::BIT_CONVERTER_ON];

            // Only the core one register drives the power switch
            if (gi == brc_pkg::SLOT_CORE_ONE) begin : g_switch
                assign sw_next = wr_here ? wr_byte[brc_pkg::BIT_SWITCH_CLOSED] :
                                 I_SEQ_SWITCH_STEP ?
                                     reg_q[gi][brc_pkg::BIT_SWITCH_SEQ] :
                                 reg_q[gi][brc_pkg::BIT_SWITCH_CLOSED];
            end else begin : g_reserved
                // Plain storage with no effect on any converter
                assign sw_next = wr_here ? wr_byte[brc_pkg::BIT_SWITCH_CLOSED] :
                                 reg_q[gi][brc_pkg::BIT_SWITCH_CLOSED];
            end

            // Remaining fields are plain read/write storage
            assign stored = wr_here ? wr_byte : reg_q[gi];

            assign reg_d[gi] = {stored[brc_pkg::BIT_SWITCH_SEQ],
                                stored[brc_pkg::VSEL_SOURCE_MSB:brc_pkg::VSEL_SOURCE_LSB],
                                sw_next,
                                stored[brc_pkg::BIT_SEQUENCER_TARGET],
                                stored[brc_pkg::ENABLE_SOURCE_MSB:brc_pkg::ENABLE_SOURCE_LSB],
                                on_next};

            // Rise picks target A (0), fall picks target B (1)
            assign vsel_d[gi] = frozen ? vsel_q[gi] :
                                v_rise ? 1'b0 :
                                v_fall ? 1'b1 :
                                vsel_q[gi];

            always_ff @(posedge I_SYS_CLK) begin
                if (I_SYS_RST) begin
                    reg_q[gi]  <= brc_pkg::REG_RESET;
                    vsel_q[gi] <= brc_pkg::VSEL_RESET;
                end else begin
                    reg_q[gi]  <= reg_d[gi];
                    vsel_q[gi] <= vsel_d[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Converter outputs
    // ------------------------------------------------------------------
    wire  [3:0]             conv_on_d;
    wire  [3:0]             conv_mask;
    wire                    switch_d;

    // Core two output is forced off in dual-phase mode
    assign conv_mask = {3'h7, ~I_DUAL_PHASE};

    generate
        for (gi = 0; gi < brc_pkg::NUM_CONV; gi++) begin : g_out
            assign conv_on_d[gi] = reg_q[gi][brc_pkg::BIT_CONVERTER_ON] & conv_mask[gi];
        end
    endgenerate

    assign switch_d = reg_q[brc_pkg::SLOT_CORE_ONE][brc_pkg::BIT_SWITCH_CLOSED];

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            conv_on_q  <= 4'h0;
            volt_alt_q <= 4'h0;
            switch_q   <= 1'b0;
        end else begin
            conv_on_q  <= conv_on_d;
            volt_alt_q <= vsel_q;
            switch_q   <= switch_d;
        end
    end

    assign O_AVS_READDATA       = rdata_q;
    assign O_AVS_WAITREQUEST    = waitreq_q;
    assign O_CONVERTER_ON       = conv_on_q;
    assign O_VOLTAGE_ALTERNATE  = volt_alt_q;
    assign O_CORE_SWITCH_CLOSED = switch_q;

endmodule // brc_buck_ctrl

// file: src/brc_pkg.sv
// Package for the buck regulator control register bank.
// Holds register indices, field positions, reset values and shared decode helpers.
package brc_pkg;

    // Bus shape
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 8;
    localparam int          BE_W         = 4;
    localparam int          REG_W        = 8;
    localparam int          NUM_CONV     = 4;
    localparam int          NUM_GPI      = 3;
    localparam int          SLOT_W       = 2;
    localparam int          IDX_W        = 6;
    localparam int          ADDR_LSB     = 2;

    // Register indices; byte address is four times the index
    localparam logic [5:0]  CORE_TWO_BUCK_CONTROL_IDX  = 6'h20;
    localparam logic [5:0]  CORE_ONE_BUCK_CONTROL_IDX  = 6'h21;
    localparam logic [5:0]  PROCESSOR_BUCK_CONTROL_IDX = 6'h22;
    localparam logic [5:0]  MEMORY_BUCK_CONTROL_IDX    = 6'h23;

    // Converter slots, in register order
    localparam int          SLOT_CORE_TWO = 0;
    localparam int          SLOT_CORE_ONE = 1;
    localparam int          SLOT_PROC     = 2;
    localparam int          SLOT_MEM      = 3;

    // Field positions within each converter register
    localparam int          BIT_CONVERTER_ON     = 0;
    localparam int          ENABLE_SOURCE_LSB    = 1;
    localparam int          ENABLE_SOURCE_MSB    = 2;
    localparam int          BIT_SEQUENCER_TARGET = 3;
    localparam int          BIT_SWITCH_CLOSED    = 4;
    localparam int          VSEL_SOURCE_LSB      = 5;
    localparam int          VSEL_SOURCE_MSB      = 6;
    localparam int          BIT_SWITCH_SEQ       = 7;

    // Reset values
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic        VSEL_RESET     = 1'h0;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
    localparam logic [23:0] RDATA_PAD      = 24'h00_0000;
    localparam logic [1:0]  ADDR_ALIGNED   = 2'h0;

    // Control source encoding shared by both select fields
    typedef enum logic [1:0] {
        SRC_SEQUENCER = 2'h0,
        SRC_FIRST     = 2'h1,
        SRC_SECOND    = 2'h2,
        SRC_THIRD     = 2'h3
    } brc_src_type;

    // Bus handshake states
    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } brc_bus_state_type;

    // Picks the event of the control input that a source field names
    function automatic logic brc_src_event(input logic [1:0] src,
                                           input logic [2:0] ev);
        logic result;
        result = 1'b0;
        unique case (brc_src_type'(src))
            SRC_SEQUENCER: result = 1'b0;
            SRC_FIRST:     result = ev[0];
            SRC_SECOND:    result = ev[1];
            SRC_THIRD:     result = ev[2];
        endcase
        return result;
    endfunction

endpackage

// file: src/brc_input_edges.sv
// Transition detector for the three control inputs.
// Assumes the inputs are already synchronous and active high.
`timescale 1ns/1ps
module brc_input_edges (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Control inputs
    input  wire logic [2:0] i_level,
    // Transition pulses
    output logic      [2:0] o_rise,
    output logic      [2:0] o_fall
);

    logic [2:0] prev_q;
    logic       armed_q;

    // Nothing is reported until one sample has been taken after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_q  <= 3'h0;
            armed_q <= 1'b0;
        end else begin
            prev_q  <= i_level;
            armed_q <= 1'b1;
        end
    end

    assign o_rise = armed_q ? (i_level & ~prev_q) : 3'h0;
    assign o_fall = armed_q ? (~i_level & prev_q) : 3'h0;

endmodule // brc_input_edges

// file: tb/brc_host_model.sv
// Host-side driver of the three regulator control inputs.
// Assumes the bench asks for levels; they reach the block just after a rising edge.
`timescale 1ns/1ps
module brc_host_model (
    // Clock
    input  wire logic       i_clk,
    // Levels asked for by the bench
    input  wire logic [2:0] i_want,
    // Control inputs of the block, first input in bit 0
    output logic      [2:0] o_ctl
);
    initial o_ctl = 3'h0;
    // Synchronous source, so the block never sees a change near its sampling edge
    always @(posedge i_clk) begin
        o_ctl <= i_want;
    end
endmodule // brc_host_model

// file: tb/brc_buck_ctrl_sva.sv
// Checker for the buck control register bank.
// Assumes it is bound to brc_buck_ctrl and sees only its ports.
`timescale 1ns/1ps
module brc_buck_ctrl_sva (
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_SYS_RST,
    // Register bus
    input  wire logic [7:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    input  wire logic [31:0] O_AVS_READDATA,
    input  wire logic        O_AVS_WAITREQUEST,
    // Control and converter outputs
    input  wire logic        I_FIRST_CONTROL_INPUT,
    input  wire logic        I_THIRD_CONTROL_INPUT,
    input  wire logic        I_SEQ_SWITCH_STEP,
    input  wire logic        I_DUAL_PHASE,
    input  wire logic [3:0]  O_CONVERTER_ON,
    input  wire logic [3:0]  O_VOLTAGE_ALTERNATE,
    input  wire logic        O_CORE_SWITCH_CLOSED
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic [7:0] shd_q [4];
    logic [1:0] vz_q;
    // Shadow of accepted writes; source fields change only by software
    wire        wr_ok = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0]
                        && I_AVS_ADDRESS[7:4] == 4'h8 && I_AVS_ADDRESS[1:0] == 2'h0;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            shd_q <= '{default: 8'h00};
            vz_q  <= 2'h0;
        end else begin
            if (wr_ok)
                shd_q[I_AVS_ADDRESS[3:2]] <= I_AVS_WRITEDATA[7:0];
            vz_q <= {vz_q[0], shd_q[1][6:5] == 2'h0};
        end
    end
    property p_wait_one; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    property p_wait_ans;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |-> ##[1:2] !O_AVS_WAITREQUEST;
    endproperty
    a_wait_ans: assert property (p_wait_ans)
        else $error("request not answered in time");
    property p_rd_hi; O_AVS_READDATA[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi)
        else $error("read data above bit 7 not zero");
    property p_dual; I_DUAL_PHASE && $past(I_DUAL_PHASE) |-> !O_CONVERTER_ON[0]; endproperty
    a_dual: assert property (p_dual)
        else $error("second core converter on in dual phase");
    property p_en_on;
        shd_q[2][2:1] == 2'h1 && $rose(I_FIRST_CONTROL_INPUT) && !I_AVS_WRITE
            |-> ##[1:3] O_CONVERTER_ON[2];
    endproperty
    a_en_on: assert property (p_en_on)
        else $error("processor converter not enabled by its input");
    property p_vsel_b;
        shd_q[3][6:5] == 2'h3 && $fell(I_THIRD_CONTROL_INPUT) && !I_AVS_WRITE
            |-> ##[1:3] O_VOLTAGE_ALTERNATE[3];
    endproperty
    a_vsel_b: assert property (p_vsel_b)
        else $error("memory voltage did not move to the alternate target");
    property p_vsel_hold;
        (&vz_q) && shd_q[1][6:5] == 2'h0 |-> $stable(O_VOLTAGE_ALTERNATE[1]);
    endproperty
    a_vsel_hold: assert property (p_vsel_hold)
        else $error("core one voltage moved while not input controlled");
    property p_sw_step;
        I_SEQ_SWITCH_STEP && !I_AVS_WRITE |-> ##[1:2] O_CORE_SWITCH_CLOSED == shd_q[1][7];
    endproperty
    a_sw_step: assert property (p_sw_step)
        else $error("switch step did not apply the switch target");
    c_read: cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
    c_gpio_on: cover property ($rose(O_CONVERTER_ON[2]));
    c_alt: cover property ($rose(O_VOLTAGE_ALTERNATE[3]));
endmodule // brc_buck_ctrl_sva

// file: tb/testbench.sv
// Self-checking bench for the buck control register bank.
// Assumes the design, the checker and the host model are compiled before it.
`timescale 1ns/1ps
module testbench;
    logic        clk, rst, rd, wr, sw_step, dual, mem_def, waitreq, sw_closed, snap;
    logic [7:0]  addr, r;
    logic [31:0] wdata, rdata;
    logic [3:0]  be, step, on, alt, e_on, e_alt;
    logic [2:0]  want, ctl, sel;
    logic        e_sw;
    logic [31:0] exp_q [$];
    string       what_q [$];
    int          fails, checks_done;
    brc_buck_ctrl dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_FIRST_CONTROL_INPUT(ctl[0]),
        .I_SECOND_CONTROL_INPUT(ctl[1]), .I_THIRD_CONTROL_INPUT(ctl[2]), .I_SEQ_STEP(step),
        .I_SEQ_SWITCH_STEP(sw_step), .I_DUAL_PHASE(dual), .I_MEM_DEFAULT_SUPPLY(mem_def),
        .O_CONVERTER_ON(on), .O_VOLTAGE_ALTERNATE(alt), .O_CORE_SWITCH_CLOSED(sw_closed));
    brc_host_model u_host (.i_clk(clk), .i_want(want), .o_ctl(ctl));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        addr  <= a;
        wdata <= d;
        be    <= b;
        wr    <= w;
        rd    <= !w;
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic note(input string w, input logic [31:0] v);
        what_q.push_back(w);
        exp_q.push_back(v);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] v);
        note("readdata", {24'h000000, v});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic outs();
        note("outputs", {23'h0, e_alt, e_on, e_sw});
        snap <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
    endtask
    task automatic drive(input logic [2:0] w);
        want <= w;
        repeat (5) @(posedge clk);
    endtask
    task automatic pulse(input logic [3:0] st, input logic sws);
        step    <= st;
        sw_step <= sws;
        @(posedge clk);
        step    <= 4'h0;
        sw_step <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Takes the oldest note whenever a read answer or an output snapshot appears
    always @(posedge clk) begin
        if ((rd && waitreq === 1'b0) || snap)
            check(what_q.pop_front(), snap ? {23'h0, alt, on, sw_closed} : rdata,
                  exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        {rst, rd, wr, sw_step, dual, mem_def, snap} = 7'h40;
        {addr, wdata, be, step, want} = '0;
        {fails, checks_done, e_on, e_alt, e_sw} = '0;
        void'($urandom(27));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
            rd_chk(8'h80 + 8'(4 * i), 8'h00);
        outs();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom) & 8'h99;
            bus(1'b1, 8'h80 + 8'(4 * i), {24'($urandom), r}, 4'hF);
            bus(1'b1, 8'h80 + 8'(4 * i), 32'h0000_00FF, 4'hE);
            rd_chk(8'h80 + 8'(4 * i), r);
            e_on[i] = r[0];
            if (i == 1)
                e_sw = r[4];
        end
        outs();
        $display("test storage done");
        for (int s = 1; s < 4; s++) begin
            sel = 3'(1 << (s - 1));
            bus(1'b1, 8'h88, {24'h0, 8'(s << 1)}, 4'hF);
            bus(1'b1, 8'h8C, {24'h0, 8'(s << 5)}, 4'hF);
            e_on[3:2] = 2'h0;
            drive(~sel);
            outs();
            drive(3'h7);
            e_on[2]  = 1'b1;
            e_alt[3] = 1'b0;
            outs();
            drive(~sel);
            e_on[2]  = 1'b0;
            e_alt[3] = 1'b1;
            outs();
            drive(3'h0);
            outs();
        end
        $display("test control inputs done");
        bus(1'b1, 8'h84, 32'h0000_0088, 4'hF);
        bus(1'b1, 8'h8C, 32'h0000_0008, 4'hF);
        bus(1'b1, 8'h88, 32'h0000_000A, 4'hF);
        {e_on[3:1], e_sw} = 4'h0;
        pulse(4'hE, 1'b1);
        {e_on[1], e_sw} = 2'h3;
        outs();
        mem_def <= 1'b1;
        pulse(4'h8, 1'b0);
        e_on[3] = 1'b1;
        outs();
        $display("test sequencer done");
        bus(1'b1, 8'h80, 32'h0000_0001, 4'hF);
        e_on[0] = 1'b1;
        outs();
        dual <= 1'b1;
        rd_chk(8'h80, 8'h01);
        e_on[0] = 1'b0;
        outs();
        // Target differs from the stored enable, so a step that acts would show
        bus(1'b1, 8'h80, 32'h0000_0008, 4'hF);
        pulse(4'h1, 1'b0);
        rd_chk(8'h80, 8'h08);
        outs();
        dual <= 1'b0;
        pulse(4'h1, 1'b0);
        e_on[0] = 1'b1;
        outs();
        $display("test dual phase done");
        stop_test();
    end
endmodule // testbench

bind brc_buck_ctrl brc_buck_ctrl_sva u_sva (
    .I_SYS_CLK             (I_SYS_CLK),
    .I_SYS_RST             (I_SYS_RST),
    .I_AVS_ADDRESS         (I_AVS_ADDRESS),
    .I_AVS_READ            (I_AVS_READ),
    .I_AVS_WRITE           (I_AVS_WRITE),
    .I_AVS_WRITEDATA       (I_AVS_WRITEDATA),
    .I_AVS_BYTEENABLE      (I_AVS_BYTEENABLE),
    .O_AVS_READDATA        (O_AVS_READDATA),
    .O_AVS_WAITREQUEST     (O_AVS_WAITREQUEST),
    .I_FIRST_CONTROL_INPUT (I_FIRST_CONTROL_INPUT),
    .I_THIRD_CONTROL_INPUT (I_THIRD_CONTROL_INPUT),
    .I_SEQ_SWITCH_STEP     (I_SEQ_SWITCH_STEP),
    .I_DUAL_PHASE          (I_DUAL_PHASE),
    .O_CONVERTER_ON        (O_CONVERTER_ON),
    .O_VOLTAGE_ALTERNATE   (O_VOLTAGE_ALTERNATE),
    .O_CORE_SWITCH_CLOSED  (O_CORE_SWITCH_CLOSED)
);
